//--- design/tag_consts.svh
`ifndef TAG_CONSTS_SVH
`define TAG_CONSTS_SVH

// Opcodes
`define OP_SELECT 8'h00
`define OP_DROP_MISMATCH 8'h05
`define OP_ARB_ROUND 8'h08
`define OP_SCROLL 8'h09
`define OP_RESET 8'h0A
`define OP_READ 8'h0C
`define OP_LOCK 8'h0F
`define OP_LOCK_STATUS 8'h11
`define OP_REPEAT 8'h15
`define OP_DROP_IDENT 8'h19
`define OP_DROP_UNIDENT 8'h1A
`define OP_WRITE 8'h1B
`define OP_VERIFY 8'h1D
`define OP_VAR_READ 8'h51

// Frame lengths in bytes, CRC included
`define LEN_BARE 5'd3
`define LEN_DROP_FLAG 5'd5
`define LEN_MATCH 5'd13
`define LEN_ADDR 5'd12
`define LEN_VAR 5'd13
`define LEN_WRITE 5'd17
`define BUF_BYTES 17

// Byte positions inside a frame
`define POS_SERIAL 5'd1
`define POS_ADDR 5'd9
`define POS_SEL_ADDR 5'd1
`define POS_SEL_WORD 5'd3
`define POS_DROP_MASK 5'd1
`define POS_DROP_DATA 5'd2

`define DROP_MASK 8'h01
`define DROP_IDENT_DATA 8'h01
`define DROP_UNIDENT_DATA 8'h00
`define SLOT_MAX 8'hFF

// One-byte reply codes
`define RPL_ACCEPT 8'h00
`define RPL_ACCEPT_FAIL 8'h00
`define RPL_ACCEPT_GOOD 8'h01
`define RPL_REJECT_FAIL 8'hFE
`define RPL_REJECT 8'hFF
`define RPL_REJECT_GOOD 8'hFF

// Register map
`define REG_STATUS 4'h0
`define REG_SLOT 4'h4
`define REG_CTRL 4'h8
`define REG_LOCK_ADDR 4'hC
`define CTRL_RST 8'h01
`define CTRL_INIT_BIT 0
`define ST_IDENT_BIT 0
`define ST_PROG_BIT 1
`define ST_LOCK_BIT 2
`define ST_STATE_LSB 3

`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400

`define FLAG_HOLD_MS 500
`define CLK_HZ 40000000

`endif

//--- design/tag_crc16.sv
`timescale 1ns/1ps
`default_nettype none
`include "tag_consts.svh"

module tag_crc16 (
	input wire logic clk,
	input wire logic nrst,
	input wire tag_pkg::rx_byte_t rx,
	output logic [15:0] crc
);
	import tag_pkg::*;

	logic [15:0] next_crc;

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int k = 0; k < 8; k++) begin
			r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
		end
		crc_step = r;
	endfunction : crc_step

	// Restarts on the first byte; zero residue after the CRC bytes
	always_comb begin
		next_crc = crc;
		if (rx.valid) begin
			next_crc = crc_step(rx.first ? `CRC_INIT : crc, rx.data);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			crc <= `CRC_INIT;
		end else begin
			crc <= next_crc;
		end
	end

endmodule : tag_crc16
`default_nettype wire

//--- design/tag_pkg.sv
package tag_pkg;

	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic [7:0] data;
	} rx_byte_t;

	typedef enum logic [1:0] {rk_none, rk_serial, rk_byte} reply_kind_t;

	typedef struct packed {
		reply_kind_t kind;
		logic [7:0] code;
	} reply_t;

	typedef struct packed {
		logic [63:0] word;
		logic locked;
	} mem_word_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic [1:0] {ts_ready, ts_arbitrate, ts_counted} tag_state_t;
	typedef enum logic {lk_idle, lk_permitted} lock_state_t;
	typedef enum logic [1:0] {ps_rx, ps_fetch, ps_exec} parse_state_t;

endpackage : tag_pkg

//--- design/tag_rng.sv
`timescale 1ns/1ps
`default_nettype none
`include "tag_consts.svh"

module tag_rng (
	input wire logic clk,
	input wire logic nrst,
	output logic rnd
);
	logic [15:0] lfsr;
	logic [15:0] next_lfsr;

	// Free-running; reader timing makes the sampled bit unpredictable
	always_comb begin
		next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ `LFSR_TAPS) : (lfsr >> 1);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lfsr <= `LFSR_SEED;
			rnd <= 1'b0;
		end else begin
			lfsr <= next_lfsr;
			rnd <= lfsr[0];
		end
	end

endmodule : tag_rng
`default_nettype wire

//--- design/tag_select_inventory_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "tag_consts.svh"
// What this block does
// - Frame fields sized opcode, address, serial, data, CRC
// - One-byte reply codes 00, 01, FE, FF
// - Only two flags: identified and program-success
// - Identified flag set on entering counted state
// - Power loss starts timer clearing identified flag
// - Power return with flag set resets timer
// - Reset command clears identified flag at once
// - Program flag tracks last programming cycle result
// - Program flag cleared by second command after write
// - Lock machine has idle and permitted, starts idle
// - Matching read/var-read/write/lock-status command permits lock, stores address
// - Lock only when permitted, same tag, same address
// - Any other or bad frame returns lock idle
// - Select with initialized memory zeroes slot, replies, arbitrates
// - Select while arbitrating replies again, else silent
// - Serial replies framed preamble, serial, CRC
// - Drop-identified with data 01: flagged tag to ready, others reply; with other data the unflagged tag goes to ready
// - Drop-unidentified: unflagged tag to ready, others reply
// - Drop-mismatch: differing memory to ready, match replies
// - Round increments slot if nonzero or random, saturating
// - Reply serial when slot is zero after round
// - Fair random bit drawn per round

module tag_select_inventory_logic #(
	parameter int HOLD_CYCLES = `FLAG_HOLD_MS * (`CLK_HZ / 1000)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire tag_pkg::rx_byte_t rx,
	input wire logic power_lost,
	input wire logic prog_pass,
	input wire logic prog_fail,
	input wire logic [63:0] tag_serial_number,
	input wire tag_pkg::mem_word_t mem_in,
	input wire tag_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic mem_rd,
	output logic [7:0] mem_addr,
	output tag_pkg::reply_t reply,
	output logic lock_go,
	output logic [7:0] lock_addr,
	output logic identified_flag
);
	import tag_pkg::*;

	localparam int FB = `BUF_BYTES;

	logic pl_meta;
	logic pl_sync;
	logic [15:0] crc_val;
	logic rnd;
	parse_state_t pstate, next_pstate;
	tag_state_t tstate, next_tstate;
	lock_state_t lock_state, next_lock_state;
	logic [FB*8-1:0] frame, next_frame;
	logic [4:0] count, next_count;
	logic crc_good, next_crc_good;
	logic [7:0] slot, next_slot;
	logic next_identified;
	logic prog_ok, next_prog_ok;
	logic [1:0] wr_age, next_wr_age;
	logic [24:0] hold_timer, next_hold_timer;
	logic [7:0] ctrl, next_ctrl;
	logic [7:0] next_reg_rdata;
	logic next_mem_rd;
	logic [7:0] next_mem_addr;
	logic next_lock_go;
	logic [7:0] next_lock_addr;
	reply_t next_reply;
	logic [7:0] op;
	logic [7:0] new_slot;
	logic [7:0] status;
	logic want_ident;
	logic frame_ok;
	logic serial_ok;
	logic in_arb;
	logic exec_arb;

	function automatic logic [7:0] byte_at(input logic [FB*8-1:0] f,
		input logic [4:0] i);
		byte_at = f[i*8 +: 8];
	endfunction : byte_at

	// First received byte lands in the top of the word
	function automatic logic [63:0] word_at(input logic [FB*8-1:0] f,
		input logic [4:0] i);
		for (int k = 0; k < 8; k++) begin
			word_at[63-k*8 -: 8] = byte_at(f, i + 5'(k));
		end
	endfunction : word_at

	function automatic logic [4:0] frame_len(input logic [7:0] o);
		case (o)
			`OP_SELECT, `OP_DROP_MISMATCH: frame_len = `LEN_MATCH;
			`OP_DROP_IDENT, `OP_DROP_UNIDENT: frame_len = `LEN_DROP_FLAG;
			`OP_ARB_ROUND, `OP_SCROLL, `OP_REPEAT, `OP_RESET: begin
				frame_len = `LEN_BARE;
			end
			`OP_READ, `OP_VERIFY, `OP_LOCK, `OP_LOCK_STATUS: begin
				frame_len = `LEN_ADDR;
			end
			`OP_VAR_READ: frame_len = `LEN_VAR;
			`OP_WRITE: frame_len = `LEN_WRITE;
			default: frame_len = 5'd0;
		endcase
	endfunction : frame_len

	function automatic logic [4:0] addr_pos(input logic [7:0] o);
		if (o == `OP_SELECT || o == `OP_DROP_MISMATCH) begin
			addr_pos = `POS_SEL_ADDR;
		end else begin
			addr_pos = `POS_ADDR;
		end
	endfunction : addr_pos

	tag_crc16 crc_i (
		.clk(clk),
		.nrst(nrst),
		.rx(rx),
		.crc(crc_val)
	);

	tag_rng rng_i (
		.clk(clk),
		.nrst(nrst),
		.rnd(rnd)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pl_meta <= 1'b0;
			pl_sync <= 1'b0;
		end else begin
			pl_meta <= power_lost;
			pl_sync <= pl_meta;
		end
	end

	assign op = frame[7:0];
	assign in_arb = (tstate == ts_arbitrate);
	assign serial_ok = (word_at(frame, `POS_SERIAL) == tag_serial_number);
	assign frame_ok = crc_good && (frame_len(op) != 5'd0) &&
		(count == frame_len(op));
	assign exec_arb = (pstate == ps_exec) && frame_ok &&
		(op == `OP_ARB_ROUND) && in_arb;

	always_comb begin
		next_pstate = pstate;
		next_tstate = tstate;
		next_lock_state = lock_state;
		next_frame = frame;
		next_count = count;
		next_crc_good = crc_good;
		next_slot = slot;
		next_identified = identified_flag;
		next_prog_ok = prog_ok;
		next_wr_age = wr_age;
		next_hold_timer = hold_timer;
		next_ctrl = ctrl;
		next_mem_rd = 1'b0;
		next_mem_addr = mem_addr;
		next_lock_go = 1'b0;
		next_lock_addr = lock_addr;
		next_reply = '{kind: rk_none, code: 8'h00};
		new_slot = slot;
		want_ident = 1'b0;
		status = 8'h00;

		case (pstate)
			ps_rx: begin
				if (rx.valid) begin
					if (rx.first) begin
						next_count = 5'd1;
						next_frame[7:0] = rx.data;
						if (wr_age == 2'd2) begin
							next_prog_ok = 1'b0;
							next_wr_age = 2'd0;
						end else if (wr_age == 2'd1) begin
							next_wr_age = 2'd2;
						end
					end else if (count < 5'(FB)) begin
						next_frame[count*8 +: 8] = rx.data;
						next_count = count + 5'd1;
					end else begin
						next_count = 5'h1F;
					end
					if (rx.last) begin
						next_pstate = ps_fetch;
						next_mem_rd = 1'b1;
						next_mem_addr = byte_at(next_frame,
							addr_pos(next_frame[7:0]));
					end
				end
			end
			ps_fetch: begin
				next_crc_good = (crc_val == 16'h0000);
				next_pstate = ps_exec;
			end
			ps_exec: begin
				next_pstate = ps_rx;
				next_lock_state = lk_idle;
				if (frame_ok) begin
					case (op)
						`OP_SELECT: begin
							if (ctrl[`CTRL_INIT_BIT] || in_arb) begin
								next_slot = 8'h00;
								next_reply.kind = rk_serial;
								next_tstate = ts_arbitrate;
							end
						end
						`OP_DROP_IDENT, `OP_DROP_UNIDENT: begin
							want_ident = (op == `OP_DROP_IDENT) &&
								(byte_at(frame, `POS_DROP_DATA) ==
								`DROP_IDENT_DATA);
							if (in_arb && byte_at(frame, `POS_DROP_MASK) ==
								`DROP_MASK) begin
								if (identified_flag == want_ident) begin
									next_tstate = ts_ready;
								end else begin
									next_slot = 8'h00;
									next_reply.kind = rk_serial;
								end
							end
						end
						`OP_DROP_MISMATCH: begin
							if (in_arb) begin
								if (mem_in.word != word_at(frame,
									`POS_SEL_WORD)) begin
									next_tstate = ts_ready;
								end else begin
									next_slot = 8'h00;
									next_reply.kind = rk_serial;
								end
							end
						end
						`OP_ARB_ROUND: begin
							if (in_arb) begin
								if (slot != 8'h00 || rnd) begin
									new_slot = (slot == `SLOT_MAX) ?
										`SLOT_MAX : slot + 8'h01;
								end
								next_slot = new_slot;
								if (new_slot == 8'h00) begin
									next_reply.kind = rk_serial;
								end
							end
						end
						`OP_RESET: begin
							next_tstate = ts_ready;
							next_identified = 1'b0;
						end
						`OP_READ, `OP_VAR_READ, `OP_WRITE,
						`OP_LOCK_STATUS: begin
							if (serial_ok) begin
								next_lock_state = lk_permitted;
								next_lock_addr = byte_at(frame, `POS_ADDR);
								next_tstate = ts_counted;
								next_identified = 1'b1;
								if (op == `OP_WRITE) begin
									next_wr_age = 2'd1;
								end
								if (op == `OP_LOCK_STATUS) begin
									next_reply.kind = rk_byte;
									if (mem_in.locked) begin
										next_reply.code = prog_ok ?
											`RPL_REJECT_GOOD :
											`RPL_REJECT_FAIL;
									end else begin
										next_reply.code = prog_ok ?
											`RPL_ACCEPT_GOOD :
											`RPL_ACCEPT_FAIL;
									end
								end
							end
						end
						`OP_VERIFY: begin
							if (serial_ok) begin
								next_tstate = ts_counted;
								next_identified = 1'b1;
							end
						end
						`OP_LOCK: begin
							if (serial_ok) begin
								next_tstate = ts_counted;
								next_identified = 1'b1;
								next_reply.kind = rk_byte;
								if (lock_state == lk_permitted &&
									byte_at(frame, `POS_ADDR) == lock_addr) begin
									next_lock_go = 1'b1;
									next_reply.code = `RPL_ACCEPT;
								end else begin
									next_reply.code = `RPL_ACCEPT_FAIL;
								end
							end
						end
						default: begin
						end
					endcase
				end
			end
			default: next_pstate = ps_rx;
		endcase

		// Programming result; a pass in the same cycle wins
		if (prog_fail || pl_sync) begin
			next_prog_ok = 1'b0;
		end
		if (prog_pass) begin
			next_prog_ok = 1'b1;
		end

		// Supply gone: parser, tag, lock, slot, reply and write age fall back; ctrl and lock_addr stay, the identified flag clears after HOLD_CYCLES
		if (pl_sync) begin
			next_pstate = ps_rx;
			next_tstate = ts_ready;
			next_lock_state = lk_idle;
			next_slot = 8'h00;
			next_reply.kind = rk_none;
			next_lock_go = 1'b0;
			next_wr_age = 2'd0;
			if (identified_flag) begin
				if (hold_timer == 25'(HOLD_CYCLES - 1)) begin
					next_identified = 1'b0;
					next_hold_timer = 25'd0;
				end else begin
					next_hold_timer = hold_timer + 25'd1;
				end
			end
		end else begin
			next_hold_timer = 25'd0;
		end

		status[`ST_IDENT_BIT] = identified_flag;
		status[`ST_PROG_BIT] = prog_ok;
		status[`ST_LOCK_BIT] = (lock_state == lk_permitted);
		status[`ST_STATE_LSB +: 2] = tstate;
		if (reg_req.wr && reg_req.addr == `REG_CTRL) begin
			next_ctrl = reg_req.wdata;
		end
		next_reg_rdata = 8'h00;
		if (reg_req.rd) begin
			case (reg_req.addr)
				`REG_STATUS: next_reg_rdata = status;
				`REG_SLOT: next_reg_rdata = slot;
				`REG_CTRL: next_reg_rdata = ctrl;
				`REG_LOCK_ADDR: next_reg_rdata = lock_addr;
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pstate <= ps_rx;
			tstate <= ts_ready;
			lock_state <= lk_idle;
			frame <= '0;
			count <= 5'd0;
			crc_good <= 1'b0;
			slot <= 8'h00;
			identified_flag <= 1'b0;
			prog_ok <= 1'b0;
			wr_age <= 2'd0;
			hold_timer <= 25'd0;
			ctrl <= `CTRL_RST;
			reg_rdata <= 8'h00;
			mem_rd <= 1'b0;
			mem_addr <= 8'h00;
			lock_go <= 1'b0;
			lock_addr <= 8'h00;
			reply <= '{kind: rk_none, code: 8'h00};
		end else begin
			pstate <= next_pstate;
			tstate <= next_tstate;
			lock_state <= next_lock_state;
			frame <= next_frame;
			count <= next_count;
			crc_good <= next_crc_good;
			slot <= next_slot;
			identified_flag <= next_identified;
			prog_ok <= next_prog_ok;
			wr_age <= next_wr_age;
			hold_timer <= next_hold_timer;
			ctrl <= next_ctrl;
			reg_rdata <= next_reg_rdata;
			mem_rd <= next_mem_rd;
			mem_addr <= next_mem_addr;
			lock_go <= next_lock_go;
			lock_addr <= next_lock_addr;
			reply <= next_reply;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	reply_code_a:
	assert property (reply.kind == rk_byte |-> reply.code inside
		{`RPL_ACCEPT, `RPL_ACCEPT_GOOD, `RPL_REJECT_FAIL, `RPL_REJECT})
		else $error("reply code outside the allowed set");

	round_reply_a:
	assert property (exec_arb && !pl_sync |=>
		(reply.kind == rk_serial) == (slot == 8'h00))
		else $error("round reply does not follow slot zero");

	slot_step_a:
	assert property (exec_arb && !pl_sync && slot != 8'h00 &&
		slot != `SLOT_MAX |=> slot == $past(slot) + 8'h01)
		else $error("slot did not step by one");

	slot_sat_a:
	assert property (exec_arb && !pl_sync && slot == `SLOT_MAX |=>
		slot == `SLOT_MAX [*2])
		else $error("slot left saturation");

	reset_clear_a:
	assert property ((pstate == ps_exec) && frame_ok && op == `OP_RESET
		|=> !identified_flag && tstate == ts_ready)
		else $error("reset command left flag or state");

	counted_flag_a:
	assert property (tstate == ts_counted |-> identified_flag)
		else $error("counted state without identified flag");

	lock_gate_a:
	assert property (lock_go |-> $past(lock_state) == lk_permitted &&
		$past(pstate) == ps_exec)
		else $error("lock issued without permission");

	err_idle_a:
	assert property ((pstate == ps_exec) && !frame_ok |=>
		lock_state == lk_idle && reply.kind == rk_none && !lock_go)
		else $error("bad frame answered or kept lock");

	prog_age_a:
	assert property (pstate == ps_rx && rx.valid && rx.first &&
		wr_age == 2'd2 && !prog_pass |=> !prog_ok)
		else $error("program flag survived second command");

	hold_clear_a:
	assert property (pl_sync && identified_flag &&
		hold_timer == 25'(HOLD_CYCLES - 1) |=> !identified_flag)
		else $error("identified flag outlived hold time");

	select_reply_a:
	assert property ((pstate == ps_exec) && frame_ok &&
		op == `OP_SELECT && ctrl[`CTRL_INIT_BIT] && !pl_sync |=>
		reply.kind == rk_serial && slot == 8'h00 && tstate == ts_arbitrate)
		else $error("select did not start arbitration");

	serial_seen_c: cover property (reply.kind == rk_serial);
	lock_done_c: cover property (lock_go);
	slot_full_c: cover property (exec_arb ##1 slot == `SLOT_MAX);
	drop_ready_c: cover property (in_arb ##1 tstate == ts_ready);

endmodule : tag_select_inventory_logic
`default_nettype wire

//--- verif/reader_model.sv
`timescale 1ns/1ps
`default_nettype none

module reader_model (
	input wire logic clk,
	input wire tag_pkg::reply_t reply,
	input wire logic lock_go,
	output tag_pkg::rx_byte_t rx
);
	import tag_pkg::*;
	reply_kind_t got_kind;
	logic [7:0] got_code;
	logic got_lock;
	int sent = 0;

	initial rx = '0;

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {b[i], 8'h00};
			repeat (8) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
		end
		return c;
	endfunction : crc16

	// Sends one frame, then watches the answer window
	task automatic send(input logic [7:0] b[$], input logic bad = 1'b0);
		logic [15:0] c;
		c = crc16(b);
		sent++;
		b.push_back(c[15:8]);
		b.push_back(c[7:0] ^ {7'h00, bad});
		got_kind = rk_none;
		got_code = 8'h00;
		got_lock = 1'b0;
		foreach (b[i]) begin
			@(posedge clk);
			rx <= '{1'b1, i == 0, i == b.size() - 1, b[i]};
		end
		@(posedge clk);
		rx <= '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
		repeat (4) begin
			@(posedge clk);
			#1;
			if (reply.kind != rk_none) begin
				got_kind = reply.kind;
				got_code = reply.code;
			end
			got_lock |= lock_go;
		end
	endtask : send
endmodule : reader_model

`default_nettype wire

//--- verif/tag_select_inventory_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tag_select_inventory_logic_tb;
	import tag_pkg::*;
	localparam logic [63:0] SER = 64'h0123456789ABCDEF;
	logic clk;
	logic nrst;
	rx_byte_t rx;
	logic power_lost;
	logic prog_pass;
	logic prog_fail;
	mem_word_t mem_in;
	reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic mem_rd;
	logic [7:0] mem_addr;
	reply_t reply;
	logic lock_go;
	logic [7:0] lock_addr;
	logic identified_flag;
	logic mem_locked;
	int err_count;
	int cmp_count;
	logic [7:0] d;
	logic [7:0] slot;
	int rd_n = 0;

	tag_select_inventory_logic #(.HOLD_CYCLES(20)) DUT (
		.clk(clk), .nrst(nrst), .rx(rx), .power_lost(power_lost),
		.prog_pass(prog_pass), .prog_fail(prog_fail),
		.tag_serial_number(SER), .mem_in(mem_in), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.reply(reply), .lock_go(lock_go), .lock_addr(lock_addr),
		.identified_flag(identified_flag)
	);
	reader_model rdr (.clk(clk), .reply(reply), .lock_go(lock_go), .rx(rx));

	// One memory fetch per received frame
	always @(posedge clk) if (mem_rd === 1'b1) rd_n++;

	// Memory byte at address a holds a
	always_comb begin
		for (int i = 0; i < 8; i++) mem_in.word[63 - i * 8 -: 8] = mem_addr + 8'(i);
		mem_in.locked = mem_locked;
	end

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done();
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic chk_k(input logic [1:0] k);
		chk("reply kind", {6'h00, k}, {6'h00, rdr.got_kind});
	endtask : chk_k

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		reg_req <= '0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a);
		@(posedge clk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		reg_req <= '0;
		#1;
		d = reg_rdata;
	endtask : reg_rd

	task automatic status(input logic [7:0] e);
		reg_rd(4'h0);
		chk("status", e, d);
	endtask : status

	task automatic sel(input logic bad = 1'b0);
		rdr.send({8'h00, 8'h00, 8'hC0, 8'hEF, 8'h04, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00}, bad);
	endtask : sel

	// Serial-addressed command with n filler bytes after the address
	task automatic addr_cmd(input logic [7:0] op, input logic [7:0] a,
		input int n);
		logic [7:0] q[$];
		q.push_back(op);
		for (int i = 7; i >= 0; i--) q.push_back(SER[i * 8 +: 8]);
		q.push_back(a);
		repeat (n) q.push_back(8'hF0);
		rdr.send(q);
	endtask : addr_cmd

	task automatic pulse(input logic p);
		@(posedge clk);
		prog_pass <= p;
		prog_fail <= !p;
		@(posedge clk);
		prog_pass <= 1'b0;
		prog_fail <= 1'b0;
	endtask : pulse

	task automatic power(input int n);
		@(posedge clk);
		power_lost <= 1'b1;
		repeat (n) @(posedge clk);
		power_lost <= 1'b0;
	endtask : power

	initial begin
		#500000;
		err_count++;
		test_done();
	end

	initial begin
		err_count = 0;
		cmp_count = 0;
		nrst = 1'b0;
		power_lost = 1'b0;
		prog_pass = 1'b0;
		prog_fail = 1'b0;
		reg_req = '0;
		mem_locked = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		status(8'h00);
		reg_rd(4'h8);
		chk("ctrl", 8'h01, d);
		reg_rd(4'h2);
		chk("unmapped", 8'h00, d);
		reg_wr(4'h8, 8'h00);
		sel();
		chk_k(2'd0);
		reg_wr(4'h8, 8'h01);
		sel();
		chk_k(2'd1);
		status(8'h08);
		sel(1'b1);
		chk_k(2'd0);
		sel();
		chk_k(2'd1);
		slot = 8'h00;
		repeat (300) begin
			rdr.send({8'h08});
			reg_rd(4'h4);
			if (slot != 8'h00) begin
				chk("slot", (slot == 8'hFF) ? 8'hFF : slot + 8'h01, d);
				chk_k(2'd0);
			end else begin
				chk("slot bit", 8'h00, d & 8'hFE);
				chk_k((d == 8'h00) ? 2'd1 : 2'd0);
			end
			slot = d;
		end
		chk("slot", 8'hFF, slot);
		rdr.send({8'h19, 8'h01, 8'h01});
		chk_k(2'd1);
		reg_rd(4'h4);
		chk("slot", 8'h00, d);
		rdr.send({8'h05, 8'h10, 8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
			8'h15, 8'h16, 8'h17});
		chk_k(2'd1);
		rdr.send({8'h05, 8'h10, 8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
			8'h15, 8'h16, 8'h18});
		chk_k(2'd0);
		status(8'h00);
		chk("mem addr", 8'h10, mem_addr);
		for (int k = 0; k < 2; k++) begin
			sel();
			rdr.send({k ? 8'h19 : 8'h1A, 8'h01, 8'h00});
			chk_k(2'd0);
			status(8'h00);
		end
		addr_cmd(8'h0C, 8'h20, 0);
		chk("ident", 8'h01, {7'h00, identified_flag});
		status(8'h15);
		chk("lock addr", 8'h20, lock_addr);
		addr_cmd(8'h0F, 8'h20, 0);
		chk("lock go", 8'h01, {7'h00, rdr.got_lock});
		chk("code", 8'h00, rdr.got_code);
		addr_cmd(8'h0C, 8'h20, 0);
		addr_cmd(8'h0F, 8'h21, 0);
		chk("lock go", 8'h00, {7'h00, rdr.got_lock});
		chk_k(2'd2);
		chk("code", 8'h00, rdr.got_code);
		addr_cmd(8'h0C, 8'h20, 0);
		rdr.send({8'h08}, 1'b1);
		status(8'h11);
		addr_cmd(8'h0F, 8'h20, 0);
		chk("lock go", 8'h00, {7'h00, rdr.got_lock});
		addr_cmd(8'h51, 8'h22, 1);
		chk("lock addr", 8'h22, lock_addr);
		addr_cmd(8'h1D, 8'h22, 0);
		status(8'h11);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			mem_locked <= k[1];
			pulse(k[0]);
			reg_rd(4'h0);
			chk("prog", {7'h00, k[0]}, {7'h00, d[1]});
			addr_cmd(8'h11, 8'h20, 0);
			chk("code", k[1] ? {7'h7F, k[0]} : {7'h00, k[0]}, rdr.got_code);
		end
		@(posedge clk);
		mem_locked <= 1'b0;
		addr_cmd(8'h1B, 8'h20, 5);
		pulse(1'b1);
		addr_cmd(8'h0C, 8'h20, 0);
		status(8'h17);
		addr_cmd(8'h0C, 8'h20, 0);
		status(8'h15);
		rdr.send({8'h0A});
		status(8'h00);
		addr_cmd(8'h0C, 8'h20, 0);
		power(16);
		repeat (40) @(posedge clk);
		status(8'h01);
		sel();
		rdr.send({8'h1A, 8'h01, 8'h00});
		chk_k(2'd1);
		rdr.send({8'h19, 8'h01, 8'h01});
		chk_k(2'd0);
		status(8'h01);
		@(posedge clk);
		power_lost <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk("ident", 8'h01, {7'h00, identified_flag});
		repeat (30) @(posedge clk);
		#1;
		chk("ident", 8'h00, {7'h00, identified_flag});
		chk("mem rd", 8'(rdr.sent), 8'(rd_n));
		power_lost <= 1'b0;
		test_done();
	end
endmodule : tag_select_inventory_logic_tb

`default_nettype wire
